/* File: shared/ats_params.svh */
/*
 * Constants for the antenna tuning sequencer: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 20 MHz core clock; included by bare name.
 */
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH

`define ATS_CLK_KHZ 20000
`define ATS_OFF_CTRL 8'h00
`define ATS_OFF_STATUS 8'h04
`define ATS_OFF_INT_STAT 8'h08
`define ATS_OFF_INT_MASK 8'h0c
`define ATS_CTRL_START_BIT 0
`define ATS_CTRL_ABORT_BIT 1
`define ATS_SENSE_LSB 16
`define ATS_EV_DONE 0
`define ATS_EV_TIMEOUT 1
`define ATS_EV_MATCH 2
`define ATS_INT_MASK_RST 3'h0
`define ATS_SETTLE_US 5000
`define ATS_TIMEOUT_MS 20000
`define ATS_HOME_PULSE_US 10
`define ATS_BRAKE_US 100
`define ATS_LMIN_PULSE_US 50
`define ATS_SETTLE_CYC ((`ATS_SETTLE_US * `ATS_CLK_KHZ) / 1000)
`define ATS_TIMEOUT_CYC (`ATS_TIMEOUT_MS * `ATS_CLK_KHZ)
`define ATS_HOME_PULSE_CYC ((`ATS_HOME_PULSE_US * `ATS_CLK_KHZ) / 1000)
`define ATS_BRAKE_CYC ((`ATS_BRAKE_US * `ATS_CLK_KHZ) / 1000)
`define ATS_LMIN_PULSE_CYC ((`ATS_LMIN_PULSE_US * `ATS_CLK_KHZ) / 1000)

`endif

/* File: shared/ats_pkg.sv */
/*
 * Types for the antenna tuning sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ats_pkg;
    typedef struct packed {
        logic tune_start;
        logic coupler_tune_select;
        logic amplifier_tune_select;
        logic phase_pos;
        logic phase_neg;
        logic mag_high;
        logic mag_low;
        logic refl_below;
        logic cap_max;
        logic ind_min;
        logic ind_max;
    } ats_sense_type;

    typedef struct packed {
        logic cap_inc;
        logic cap_dec;
        logic ind_inc;
        logic ind_dec;
        logic brake;
        logic lmin_line;
    } ats_drive_type;
endpackage : ats_pkg

/* File: verilog/ats_sequencer.sv */
/*
 * Antenna tuning sequencer: tune latches, home and servo drive gating,
 * match detection, completion and timeout, APB registers, interrupt.
 * Assumes field inputs are level signals from switches and detectors;
 * all of them are synchronised here before use.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
// What this block does
// RQ1 - operator selects tune mode, then requests start; a CTRL start bit write starts a cycle with no mode selected
// RQ2 - start sets tune, fault; clears match; homes
// RQ3 - tune latch keys transmitter, lights tuning lamp
// RQ4 - home pulses set capacitor and inductor homes
// RQ5 - positive phase withdraws home, servo takes over
// RQ6 - below threshold sets match, releases attenuator
// RQ7 - match suppresses level changer servo drive
// RQ8 - match fires brake, blocks home preamp inputs
// RQ9 - settled match signals completion, ends cycle
// RQ10 - positive phase, high impedance clears force
// RQ11 - home pulse blocks positive-phase capacitor drive
// RQ12 - below threshold blocks all four drives
// RQ13 - inductor minimum raises combined condition line
// RQ14 - inductor minimum edge pulses inductor drive
// RQ15 - capacitor home inhibits combined condition line
// RQ16 - capacitor maximum clears home, stops drive
// RQ17 - inductor minimum clears inductor home latch
// RQ18 - all field inputs pass two-stage synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "ats_params.svh"

module ats_sequencer import ats_pkg::*; #(
    parameter int unsigned SETTLE_CYC = `ATS_SETTLE_CYC,
    parameter int unsigned TIMEOUT_CYC = `ATS_TIMEOUT_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic IRQ_OUT,
    input wire logic TUNE_START_IN,
    input wire logic COUPLER_TUNE_SELECT_IN,
    input wire logic AMPLIFIER_TUNE_SELECT_IN,
    input wire logic PHASE_POS_IN,
    input wire logic PHASE_NEG_IN,
    input wire logic MAG_HIGH_IN,
    input wire logic MAG_LOW_IN,
    input wire logic REFL_BELOW_IN,
    input wire logic CAP_MAX_IN,
    input wire logic IND_MIN_IN,
    input wire logic IND_MAX_IN,
    output logic KEY_TX_OUT,
    output logic TUNING_LAMP_OUT,
    output logic FAULT_LAMP_OUT,
    output logic COMPLETE_OUT,
    output logic ATTENUATOR_RELAY_OUT,
    output logic CAP_INC_OUT,
    output logic CAP_DEC_OUT,
    output logic IND_INC_OUT,
    output logic IND_DEC_OUT,
    output logic BRAKE_OUT,
    output logic LMIN_LINE_OUT
);
    localparam int SW = $bits(ats_sense_type);
    localparam logic [15:0] HOME_CYC = 16'(`ATS_HOME_PULSE_CYC);
    localparam logic [15:0] BRAKE_CYC = 16'(`ATS_BRAKE_CYC);
    localparam logic [15:0] LMIN_CYC = 16'(`ATS_LMIN_PULSE_CYC);

    ats_sense_type raw;
    ats_sense_type s;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;

    assign raw = '{TUNE_START_IN, COUPLER_TUNE_SELECT_IN, AMPLIFIER_TUNE_SELECT_IN,
                   PHASE_POS_IN, PHASE_NEG_IN, MAG_HIGH_IN, MAG_LOW_IN,
                   REFL_BELOW_IN, CAP_MAX_IN, IND_MIN_IN, IND_MAX_IN};

    genvar gi;
    generate
        for (gi = 0; gi < SW; gi++) begin : g_sync
            always_ff @(posedge CORE_CLK_IN) begin
                if (RST_IN) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw[gi]; // [RQ18]
                    sync2_reg[gi] <= sync1_reg[gi]; // [RQ18]
                end
            end
        end
    endgenerate
    assign s = ats_sense_type'(sync2_reg);

    // latches and counters
    logic tune_active_reg, fault_latch_reg, matched_latch_reg, complete_reg;
    logic cap_home_latch_reg, ind_home_latch_reg, ind_force_latch_reg, servo_en_reg;
    logic start_q_reg, ind_min_q_reg;
    logic [15:0] home_cnt_reg, brake_cnt_reg, lmin_cnt_reg;
    logic [31:0] settle_cnt_reg, timeout_cnt_reg;
    ats_drive_type drive_reg;
    ats_drive_type drive_next;
    logic [2:0] int_stat_reg, int_mask_reg;
    logic [31:0] prdata_reg;

    // apb decode
    wire setup = PSEL_IN & ~PENABLE_IN;
    wire access = PSEL_IN & PENABLE_IN;
    wire hit_ctrl = PADDR_IN == `ATS_OFF_CTRL;
    wire hit_stat = PADDR_IN == `ATS_OFF_STATUS;
    wire hit_int = PADDR_IN == `ATS_OFF_INT_STAT;
    wire hit_mask = PADDR_IN == `ATS_OFF_INT_MASK;
    wire mapped = hit_ctrl | hit_stat | hit_int | hit_mask;
    wire wr_ctrl = access & PWRITE_IN & hit_ctrl;
    wire sw_start = wr_ctrl & PWDATA_IN[`ATS_CTRL_START_BIT];
    wire sw_abort = wr_ctrl & PWDATA_IN[`ATS_CTRL_ABORT_BIT];
    wire rd_int = access & ~PWRITE_IN & hit_int;
    wire [31:0] status_word = {5'h00, 11'(sync2_reg), 8'h00, complete_reg, servo_en_reg,
                               ind_force_latch_reg, ind_home_latch_reg,
                               cap_home_latch_reg, fault_latch_reg,
                               matched_latch_reg, tune_active_reg};
    wire [31:0] rd_mux = hit_stat ? status_word :
                         hit_int ? {29'h0, int_stat_reg} :
                         hit_mask ? {29'h0, int_mask_reg} : 32'h0;

    // sequencing terms
    wire mode_ok = s.coupler_tune_select | s.amplifier_tune_select; // [RQ1]
    wire start_evt = (s.tune_start & ~start_q_reg & mode_ok) | sw_start;
    wire home_pulse = home_cnt_reg != 16'h0;
    wire ind_min_rise = s.ind_min & ~ind_min_q_reg;
    wire settled = tune_active_reg & s.refl_below & (settle_cnt_reg == SETTLE_CYC - 1);
    wire timed_out = tune_active_reg & ~settled & (timeout_cnt_reg == TIMEOUT_CYC - 1);
    wire match_rise = s.refl_below & ~matched_latch_reg & tune_active_reg;
    wire phase_take = tune_active_reg & ~home_pulse & s.phase_pos;
    wire lc_en = servo_en_reg & ~matched_latch_reg; // [RQ7]
    wire home_en = ~matched_latch_reg; // [RQ8]
    wire run = tune_active_reg & ~s.refl_below; // [RQ12]
    wire ind_dec_raw = run & ~s.ind_min &
                       ((ind_home_latch_reg & home_en) | (lc_en & s.mag_high));
    wire [2:0] events = {match_rise, timed_out, settled};

    always_comb begin
        drive_next = '0;
        drive_next.cap_inc = run & ~s.cap_max & // [RQ16]
                             ((cap_home_latch_reg & home_en) | (lc_en & s.phase_neg));
        drive_next.cap_dec = run & ~home_pulse & lc_en & s.phase_pos; // [RQ11]
        drive_next.ind_dec = ind_dec_raw;
        drive_next.ind_inc = run & ~s.ind_max & ~ind_dec_raw & // [RQ14]
                             ((lmin_cnt_reg != 16'h0) | ind_force_latch_reg | (lc_en & s.mag_low));
        drive_next.brake = brake_cnt_reg != 16'h0; // [RQ8]
        drive_next.lmin_line = s.ind_min & ~cap_home_latch_reg & ~s.cap_max; // [RQ13] [RQ15]
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            tune_active_reg <= 1'b0;
            fault_latch_reg <= 1'b0;
            complete_reg <= 1'b0;
            start_q_reg <= 1'b0;
            ind_min_q_reg <= 1'b0;
        end else begin
            start_q_reg <= s.tune_start;
            ind_min_q_reg <= s.ind_min;
            if (start_evt) begin
                tune_active_reg <= 1'b1; // [RQ2]
                fault_latch_reg <= 1'b1; // [RQ2]
                complete_reg <= 1'b0;
            end else if (settled) begin
                tune_active_reg <= 1'b0; // [RQ9]
                fault_latch_reg <= 1'b0;
                complete_reg <= 1'b1; // [RQ9]
            end else if (timed_out | sw_abort) begin
                tune_active_reg <= 1'b0;
            end
        end
    end

    // match tracks the detector and may toggle before settling
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN | start_evt) begin
            matched_latch_reg <= 1'b0; // [RQ2]
        end else begin
            matched_latch_reg <= tune_active_reg & s.refl_below; // [RQ6]
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            cap_home_latch_reg <= 1'b0;
            ind_home_latch_reg <= 1'b0;
            servo_en_reg <= 1'b0;
            home_cnt_reg <= 16'h0;
        end else if (start_evt) begin
            cap_home_latch_reg <= 1'b1; // [RQ4]
            ind_home_latch_reg <= 1'b1; // [RQ4]
            servo_en_reg <= 1'b0;
            home_cnt_reg <= HOME_CYC; // [RQ2]
        end else begin
            home_cnt_reg <= home_pulse ? home_cnt_reg - 16'h1 : 16'h0;
            if (s.cap_max | phase_take | ~tune_active_reg) begin
                cap_home_latch_reg <= 1'b0; // [RQ16] [RQ5]
            end
            if (ind_min_rise | phase_take | ~tune_active_reg) begin
                ind_home_latch_reg <= 1'b0; // [RQ17] [RQ5]
            end
            servo_en_reg <= tune_active_reg & (servo_en_reg | phase_take); // [RQ5]
        end
    end

    // force drives the inductor off minimum when the capacitor is at max
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN | start_evt | s.refl_below | (s.phase_pos & s.mag_high)) begin
            ind_force_latch_reg <= 1'b0; // [RQ10]
        end else if (tune_active_reg & s.ind_min & s.cap_max) begin
            ind_force_latch_reg <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN | start_evt) begin
            settle_cnt_reg <= 32'h0; // [RQ2]
            timeout_cnt_reg <= 32'h0; // [RQ2]
        end else begin
            settle_cnt_reg <= (tune_active_reg & s.refl_below) ? settle_cnt_reg + 32'h1 : 32'h0;
            timeout_cnt_reg <= tune_active_reg ? timeout_cnt_reg + 32'h1 : 32'h0;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            brake_cnt_reg <= 16'h0;
            lmin_cnt_reg <= 16'h0;
            drive_reg <= '0;
        end else begin
            brake_cnt_reg <= match_rise ? BRAKE_CYC :
                             (drive_next.brake ? brake_cnt_reg - 16'h1 : 16'h0);
            lmin_cnt_reg <= ind_min_rise ? LMIN_CYC :
                            ((lmin_cnt_reg != 16'h0) ? lmin_cnt_reg - 16'h1 : 16'h0);
            drive_reg <= drive_next;
        end
    end

    // read data is caught in setup; only the bits seen are cleared
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            prdata_reg <= 32'h0;
            int_stat_reg <= 3'h0;
            int_mask_reg <= `ATS_INT_MASK_RST;
        end else begin
            if (setup) begin
                prdata_reg <= rd_mux;
            end
            int_stat_reg <= events | (int_stat_reg & ~(rd_int ? prdata_reg[2:0] : 3'h0));
            if (access & PWRITE_IN & hit_mask) begin
                int_mask_reg <= PWDATA_IN[2:0];
            end
        end
    end

    assign PREADY_OUT = access;
    assign PSLVERR_OUT = access & ~mapped;
    assign PRDATA_OUT = prdata_reg;
    assign IRQ_OUT = |(int_stat_reg & int_mask_reg);
    assign KEY_TX_OUT = tune_active_reg; // [RQ3]
    assign TUNING_LAMP_OUT = tune_active_reg; // [RQ3]
    assign FAULT_LAMP_OUT = fault_latch_reg;
    assign COMPLETE_OUT = complete_reg;
    assign ATTENUATOR_RELAY_OUT = tune_active_reg & ~matched_latch_reg; // [RQ6]
    assign CAP_INC_OUT = drive_reg.cap_inc;
    assign CAP_DEC_OUT = drive_reg.cap_dec;
    assign IND_INC_OUT = drive_reg.ind_inc;
    assign IND_DEC_OUT = drive_reg.ind_dec;
    assign BRAKE_OUT = drive_reg.brake;
    assign LMIN_LINE_OUT = drive_reg.lmin_line;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_start;
        start_evt |=> tune_active_reg && fault_latch_reg && !matched_latch_reg;
    endproperty
    a_start: assert property (p_start) else $error("start did not set latches"); // [RQ2]

    property p_home;
        start_evt |=> cap_home_latch_reg && ind_home_latch_reg && home_pulse;
    endproperty
    a_home: assert property (p_home) else $error("home latches not set"); // [RQ4]

    property p_key;
        $rose(tune_active_reg) |-> KEY_TX_OUT && TUNING_LAMP_OUT && !COMPLETE_OUT;
    endproperty
    a_key: assert property (p_key) else $error("transmitter not keyed"); // [RQ3]

    property p_block;
        s.refl_below |=> !CAP_INC_OUT && !CAP_DEC_OUT && !IND_INC_OUT && !IND_DEC_OUT;
    endproperty
    a_block: assert property (p_block) else $error("drive while matched"); // [RQ12]

    property p_cap_excl;
        !(CAP_INC_OUT && CAP_DEC_OUT) and (home_pulse |=> !CAP_DEC_OUT);
    endproperty
    a_cap_excl: assert property (p_cap_excl) else $error("capacitor double drive"); // [RQ11]

    property p_capmax;
        s.cap_max && !start_evt |=> !cap_home_latch_reg && !CAP_INC_OUT;
    endproperty
    a_capmax: assert property (p_capmax) else $error("capacitor max ignored"); // [RQ16]

    property p_indmin;
        ind_min_rise && !start_evt |=> !ind_home_latch_reg;
    endproperty
    a_indmin: assert property (p_indmin) else $error("inductor home not cleared"); // [RQ17]

    property p_force;
        ind_force_latch_reg && s.phase_pos && s.mag_high |=> !ind_force_latch_reg;
    endproperty
    a_force: assert property (p_force) else $error("force latch not cleared"); // [RQ10]

    property p_brake;
        match_rise |=> ##1 BRAKE_OUT [*2];
    endproperty
    a_brake: assert property (p_brake) else $error("no brake pulse on match"); // [RQ8]

    property p_done;
        settled && !start_evt |=> COMPLETE_OUT && !tune_active_reg && !FAULT_LAMP_OUT;
    endproperty
    a_done: assert property (p_done) else $error("completion not signalled"); // [RQ9]

    c_done: cover property (settled);
    c_timeout: cover property (timed_out);
    c_force: cover property ($rose(ind_force_latch_reg));
    c_retoggle: cover property ($fell(matched_latch_reg) && tune_active_reg);
endmodule : ats_sequencer

`default_nettype wire

/* File: verif/ats_far_side_model.sv */
/*
 * Far side of the tuning sequencer: capacitor and roller inductor
 * positions moved by the drive levels, with their limit switches.
 * Assumes one clock shared with the sequencer; preset parks both elements.
 */
`timescale 1ns/1ps
`default_nettype none

module ats_far_side_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic preset_in,
    input wire logic [4:0] cap_init_in,
    input wire logic [4:0] ind_init_in,
    input wire logic cap_inc_in,
    input wire logic cap_dec_in,
    input wire logic ind_inc_in,
    input wire logic ind_dec_in,
    output logic cap_max_out,
    output logic ind_min_out,
    output logic ind_max_out
);
    logic [4:0] cap_reg;
    logic [4:0] ind_reg;
    logic [2:0] tick_reg;
    wire logic step = (tick_reg == 3'h7);

    // motors are slow: one step per eight cycles, opposing drives cancel
    always_ff @(posedge clk_in) begin
        if (rst_in || preset_in) begin
            cap_reg <= cap_init_in;
            ind_reg <= ind_init_in;
            tick_reg <= 3'h0;
        end else begin
            tick_reg <= tick_reg + 3'h1;
            if (step && cap_inc_in && !cap_dec_in && cap_reg != 5'h1f) cap_reg <= cap_reg + 5'h1;
            if (step && cap_dec_in && !cap_inc_in && cap_reg != 5'h00) cap_reg <= cap_reg - 5'h1;
            if (step && ind_inc_in && !ind_dec_in && ind_reg != 5'h1f) ind_reg <= ind_reg + 5'h1;
            if (step && ind_dec_in && !ind_inc_in && ind_reg != 5'h00) ind_reg <= ind_reg - 5'h1;
        end
    end

    assign cap_max_out = (cap_reg == 5'h1f);
    assign ind_min_out = (ind_reg == 5'h00);
    assign ind_max_out = (ind_reg == 5'h1f);
endmodule : ats_far_side_model

`default_nettype wire

/* File: verif/tb_antenna_tuning_sequencer.sv */
/*
 * Self-checking bench for the tuning sequencer with a motor model.
 * Assumes zero-wait APB answers and the short settle and timeout counts set here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ats_params.svh"

module tb_antenna_tuning_sequencer;
    localparam int SETTLE = 20;
    localparam int TMO = 1500;
    typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic er; bit pr;} ats_note_type;
    ats_note_type notes[$];
    ats_note_type n;
    logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, prb = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, key, lamp, fault, done, att, ci, cd, ii, id, brk, lmin;
    logic start = 1'h0, cpl = 1'h0, amp = 1'h0, ppos = 1'h0, mhi = 1'h0, refl = 1'h0;
    logic cmax, imin, imax;
    logic pre = 1'h1;
    logic [4:0] cinit = 5'h10, iinit = 5'h04;
    int checked = 0, bad_count = 0, cycles = 0;
    wire logic [11:0] outs = {key, lamp, fault, done, att, ci, cd, ii, id, brk, lmin, irq};

    always #25 clk = ~clk;

    ats_sequencer #(.SETTLE_CYC(SETTLE), .TIMEOUT_CYC(TMO)) u_dut (
        .CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .TUNE_START_IN(start),
        .COUPLER_TUNE_SELECT_IN(cpl), .AMPLIFIER_TUNE_SELECT_IN(amp),
        .PHASE_POS_IN(ppos), .PHASE_NEG_IN(~ppos), .MAG_HIGH_IN(mhi), .MAG_LOW_IN(~mhi),
        .REFL_BELOW_IN(refl), .CAP_MAX_IN(cmax), .IND_MIN_IN(imin), .IND_MAX_IN(imax),
        .KEY_TX_OUT(key), .TUNING_LAMP_OUT(lamp), .FAULT_LAMP_OUT(fault), .COMPLETE_OUT(done),
        .ATTENUATOR_RELAY_OUT(att), .CAP_INC_OUT(ci), .CAP_DEC_OUT(cd), .IND_INC_OUT(ii),
        .IND_DEC_OUT(id), .BRAKE_OUT(brk), .LMIN_LINE_OUT(lmin));

    ats_far_side_model u_far (.clk_in(clk), .rst_in(rst), .preset_in(pre),
        .cap_init_in(cinit), .ind_init_in(iinit), .cap_inc_in(ci), .cap_dec_in(cd),
        .ind_inc_in(ii), .ind_dec_in(id), .cap_max_out(cmax), .ind_min_out(imin),
        .ind_max_out(imax));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic er, input string nm);
        notes.push_back('{nm, e, m, er, 1'b0});
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic probe(input string nm, input logic [11:0] e, input logic [11:0] m);
        notes.push_back('{nm, {20'h0, e}, {20'h0, m}, 1'h0, 1'b1});
        @(posedge clk);
        prb <= 1'h1;
        @(posedge clk);
        prb <= 1'h0;
    endtask : probe

    task automatic press();
        @(posedge clk);
        start <= 1'h1;
        repeat (4) @(posedge clk);
        start <= 1'h0;
    endtask : press

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // results are taken off the note queue in the order they were requested
    always @(posedge clk) begin
        if ((psel && pen && pready === 1'h1) || prb) begin
            n = notes.pop_front();
            if (n.pr) check(n.nm, {20'h0, outs} & n.m, n.e & n.m);
            else begin
                if (!pwr) check(n.nm, prdata & n.m, n.e & n.m);
                check("pslverr", {31'h0, pslverr}, {31'h0, n.er});
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'hc087));
        cinit = 5'h10 + 5'($urandom % 8);
        iinit = 5'h04 + 5'($urandom % 4);
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        pre <= 1'h0;
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h0, 32'hffffffff, 1'h0, "status_rst");
        apb(1'h0, `ATS_OFF_INT_MASK, 32'h0, {29'h0, `ATS_INT_MASK_RST}, 32'h7, 1'h0, "mask_rst");
        apb(1'h1, 8'h10, $urandom, 32'h0, 32'h0, 1'h1, "unmapped_wr");
        apb(1'h0, 8'h10, 32'h0, 32'h0, 32'hffffffff, 1'h1, "unmapped_rd");
        apb(1'h1, `ATS_OFF_INT_MASK, 32'h7, 32'h0, 32'h0, 1'h0, "mask_wr");
        apb(1'h0, `ATS_OFF_INT_MASK, 32'h0, 32'h7, 32'h7, 1'h0, "mask_rd");
        press();
        repeat (8) @(posedge clk);
        probe("refused", 12'h000, 12'hfff); // button ignored without mode select
        cpl <= 1'h1; // mode selected before the button
        ppos <= 1'h1;
        press();
        repeat (4) @(posedge clk);
        probe("homing", 12'hec0, 12'hfe0); // keyed, homing
        ppos <= 1'h0;
        repeat (200) if (imin !== 1'h1) @(posedge clk);
        repeat (6) @(posedge clk);
        probe("ind_min", 12'h050, 12'h052); // kick pulse, line held off
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h0200000d, 32'h0780001f, 1'h0,
            "st_imin");
        repeat (300) if (cmax !== 1'h1) @(posedge clk);
        repeat (6) @(posedge clk);
        probe("cap_max", 12'h000, 12'h042); // max drive removed
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h02040005, 32'h0784001f, 1'h0,
            "st_cmax");
        repeat (100) @(posedge clk);
        ppos <= 1'h1;
        mhi <= 1'h1;
        repeat (8) @(posedge clk);
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h40, 32'h58, 1'h0, "st_servo"); // servo on
        probe("servo", 12'h028, 12'h078); // error drive moves both elements
        refl <= 1'h1;
        repeat (6) @(posedge clk);
        probe("matched", 12'h804, 12'h8fc); // drives cut
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h3, 32'h3, 1'h0, "st_match"); // match latched
        repeat (SETTLE + 10) @(posedge clk);
        probe("complete", 12'h101, 12'hf01); // cycle ended, done raised
        apb(1'h0, `ATS_OFF_INT_STAT, 32'h0, 32'h5, 32'h7, 1'h0, "int_done");
        apb(1'h0, `ATS_OFF_INT_STAT, 32'h0, 32'h0, 32'h7, 1'h0, "int_clear");
        probe("irq_clear", 12'h000, 12'h001);
        pre <= 1'h1;
        cinit <= 5'h0a;
        iinit <= 5'h00;
        repeat (8) @(posedge clk);
        probe("lmin_line", 12'h002, 12'h002); // minimum inductance raises the line
        ppos <= 1'h0;
        mhi <= 1'h0;
        refl <= 1'h0;
        cpl <= 1'h0;
        amp <= 1'h1; // the other tune mode also starts a cycle
        iinit <= 5'h0a;
        cinit <= 5'h1c; // capacitor reaches max first, so minimum inductance sets force
        repeat (2) @(posedge clk);
        pre <= 1'h0;
        press();
        repeat (200) @(posedge clk);
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h20, 32'h20, 1'h0, "st_force");
        ppos <= 1'h1;
        mhi <= 1'h1;
        repeat (6) @(posedge clk);
        apb(1'h0, `ATS_OFF_STATUS, 32'h0, 32'h0, 32'h20, 1'h0, "st_unforce");
        repeat (TMO - 160) @(posedge clk);
        probe("timeout", 12'h201, 12'he01);
        apb(1'h0, `ATS_OFF_INT_STAT, 32'h0, 32'h2, 32'h7, 1'h0, "int_timeout");
        apb(1'h1, `ATS_OFF_CTRL, 32'h1, 32'h0, 32'h0, 1'h0, "ctrl_start");
        probe("sw_start", 12'he00, 12'he00);
        apb(1'h1, `ATS_OFF_CTRL, 32'h2, 32'h0, 32'h0, 1'h0, "ctrl_abort");
        probe("sw_abort", 12'h200, 12'he00); // abort keeps the fault lamp lit
        test_done();
    end
endmodule : tb_antenna_tuning_sequencer

`default_nettype wire
